// >>> verilog/smr_pkg.sv
// Constants, defaults and helpers shared by the serial message recognizer
// How it works
// - Received bytes are analysed only while the recognizer enable input is high.
// - A software-loaded delimiter of hex bytes is compared against incoming bytes.
// - A capture stores text, hex digits and digest in persistent and live slots.
// - A message spans bytes since the last capture up to and including the delimiter.
// - Live slots are erased once the programmed active timeout in ms has elapsed.
// - Timeout clears only live slots; persistent slots keep the last message.
// - All stored forms are presented as registered outputs for an event engine.
// - Reset or reload restores the delimiter to 0d then 0a.
// - With accept timeout on, pending bytes are captured after that idle time.
// - A clear command erases the stored message slots unless a capture falls in the same cycle.
// - Operation does not depend on any serial operation mode setting.
package smr_pkg;

  // Clock and millisecond tick
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES_DOC = CLK_HZ / MS_PER_S;

  // Sizes
  localparam int unsigned MSG_MAX_DOC   = 16;
  localparam int unsigned DELIM_MAX_DOC = 4;
  localparam int unsigned MS_W          = 16;
  localparam int unsigned DLEN_W        = 3;

  // Delimiter defaults: last byte sits in the low lane
  localparam logic [31:0]       DELIM_DEFAULT     = 32'h0000_0d0a;
  localparam logic [DLEN_W-1:0] DELIM_LEN_DEFAULT = 3'h2;

  // Active timeout as shown in the example, in ms
  localparam logic [MS_W-1:0] ACTIVE_TO_MS_DOC = 16'h0064;

  // FNV-1a digest constants
  localparam logic [31:0] FNV_OFFSET = 32'h811c_9dc5;
  localparam logic [31:0] FNV_PRIME  = 32'h0100_0193;

  // ASCII bases for hex digits
  localparam logic [7:0] ASCII_ZERO   = 8'h30;
  localparam logic [7:0] ASCII_A_BIAS = 8'h37;
  localparam logic [3:0] NIB_TEN      = 4'ha;

  function automatic logic [7:0] smr_hexch(input logic [3:0] nib);
    smr_hexch = (nib < NIB_TEN) ? (ASCII_ZERO + {4'h0, nib}) : (ASCII_A_BIAS + {4'h0, nib});
  endfunction

  function automatic logic [31:0] smr_fnv(input logic [31:0] h, input logic [7:0] b);
    logic [63:0] p;
    p = {32'h0, h ^ {24'h0, b}} * {32'h0, FNV_PRIME};
    smr_fnv = p[31:0];
  endfunction

endpackage : smr_pkg

// >>> verilog/smr_skid_buf.sv
// Two-entry byte buffer with valid/ready on both sides
module smr_skid_buf #(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         room_q;

  // Handshake decode
  wire push = ce & in_valid & room_q;
  wire pop  = ce & out_ready & (cnt_q != 2'h0);

  assign in_ready  = room_q;
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];

  // Storage is not reset; only pointers carry control meaning
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end

  // Pointers and a registered room flag, so in_ready leaves straight from a flop
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      cnt_q  <= 2'h0;
      room_q <= 1'b1;
    end
    else
    begin
      if (push) wp_q <= ~wp_q;
      if (pop)  rp_q <= ~rp_q;
      cnt_q  <= cnt_q + {1'b0, push} - {1'b0, pop};
      room_q <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h2;
    end
  end

endmodule // smr_skid_buf

// >>> verilog/smr_recognizer.sv
// Serial message recognizer: delimiter match, capture, digest and slot timeouts
module smr_recognizer #(
  parameter int unsigned MSG_MAX   = smr_pkg::MSG_MAX_DOC,
  parameter int unsigned DELIM_MAX = smr_pkg::DELIM_MAX_DOC,
  parameter int unsigned MS_CYCLES = smr_pkg::MS_CYCLES_DOC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        recognizer_en,
  input  wire logic [7:0]                  rx_data,
  input  wire logic                        rx_valid,
  output logic                             rx_ready,
  input  wire logic                        delim_wr,
  input  wire logic [DELIM_MAX*8-1:0]      delim_wr_data,
  input  wire logic [smr_pkg::DLEN_W-1:0]  delim_wr_len,
  input  wire logic                        defaults_reload,
  input  wire logic                        clear_slots,
  input  wire logic                        accept_to_en,
  input  wire logic [smr_pkg::MS_W-1:0]    accept_to_ms,
  input  wire logic [smr_pkg::MS_W-1:0]    active_to_ms,
  output logic [DELIM_MAX*8-1:0]           delim_bytes,
  output logic [smr_pkg::DLEN_W-1:0]       delim_len,
  output logic [MSG_MAX*8-1:0]             last_message_text,
  output logic [MSG_MAX*16-1:0]            last_message_hexdigits,
  output logic [31:0]                      last_message_digest,
  output logic [$clog2(MSG_MAX+1)-1:0]     last_message_len,
  output logic [MSG_MAX*8-1:0]             live_message_text,
  output logic [MSG_MAX*16-1:0]            live_message_hexdigits,
  output logic [MSG_MAX*16-1:0]            live_hexdigits_alias,
  output logic [31:0]                      live_message_digest,
  output logic                             live_valid,
  output logic                             capture_done
);
  import smr_pkg::*;

  localparam int unsigned LW = $clog2(MSG_MAX + 1);
  localparam int unsigned PW = $clog2(MS_CYCLES + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYCLES - 1);
  localparam logic [LW-1:0] LEN_MAX  = LW'(MSG_MAX);
  localparam int unsigned   DW       = DELIM_MAX * 8;
  // Default delimiter widened to the lane count, last byte in the low lane
  localparam logic [DW-1:0] DELIM_RST = DW'(DELIM_DEFAULT);

  // Refuse shapes the match and buffer logic cannot serve
  if (DELIM_MAX < DELIM_LEN_DEFAULT || DELIM_MAX > 7 || MSG_MAX < DELIM_MAX || MS_CYCLES < 1)
  begin : g_bad_params
    $error("smr_recognizer: unsupported parameter values");
  end

  // Input buffer toward the byte source
  logic [7:0] b_data;
  logic       b_valid;
  logic       b_ready;
  logic       cap_q;

  smr_skid_buf #(
    .W (8)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .ce        (ce),
    .in_data   (rx_data),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (b_data),
    .out_valid (b_valid),
    .out_ready (b_ready)
  );

  // Working message state
  logic [MSG_MAX*8-1:0]   cur_text_q;
  logic [LW-1:0]          cur_len_q;
  logic [31:0]            cur_hash_q;
  logic [DELIM_MAX*8-1:0] win_q;
  logic [MS_W-1:0]        idle_ms_q;
  logic [MS_W-1:0]        live_ms_q;
  logic [PW-1:0]          pre_q;
  logic [DELIM_MAX*8-1:0] delim_q;
  logic [DLEN_W-1:0]      dlen_q;

  // Hold the byte after a capture so the working buffer restarts cleanly
  assign b_ready = recognizer_en ? ~cap_q : 1'b1;
  // Disabled port drains and drops its bytes
  wire take = ce & b_valid & b_ready & recognizer_en;

  // Millisecond tick
  wire ms_tick = (pre_q == PRE_LAST);

  // Append the new byte; bytes beyond capacity still feed the digest
  logic [MSG_MAX*8-1:0]   text_app;
  logic [MSG_MAX*16-1:0]  hex_app;
  logic [DELIM_MAX*8-1:0] dmask;
  wire  [LW-1:0]          len_app  = (take && cur_len_q < LEN_MAX) ? cur_len_q + LW'(1) : cur_len_q;
  wire  [31:0]            hash_app = take ? smr_fnv(cur_hash_q, b_data) : cur_hash_q;
  wire  [DELIM_MAX*8-1:0] win_app;

  if (DELIM_MAX > 1)
  begin : g_win
    assign win_app = take ? {win_q[(DELIM_MAX-1)*8-1:0], b_data} : win_q;
  end
  else
  begin : g_win1
    assign win_app = take ? b_data : win_q;
  end

  for (genvar i = 0; i < MSG_MAX; i++)
  begin : g_byte
    wire sel = take && (cur_len_q == LW'(i));
    assign text_app[8*i +: 8] = sel ? b_data : cur_text_q[8*i +: 8];
    // High nibble digit first, blank beyond the message length
    assign hex_app[16*i +: 16] = (LW'(i) < len_app) ?
      {smr_hexch(text_app[8*i +: 4]), smr_hexch(text_app[8*i+4 +: 4])} : 16'h0000;
  end

  for (genvar j = 0; j < DELIM_MAX; j++)
  begin : g_mask
    assign dmask[8*j +: 8] = (DLEN_W'(j) < dlen_q) ? 8'hff : 8'h00;
  end

  // Match the newest bytes against the delimiter; needs enough bytes seen
  wire hit_delim = take && (dlen_q != '0) && (len_app >= LW'(dlen_q))
                   && (((win_app ^ delim_q) & dmask) == '0);
  // Idle time since the last byte closes a pending message; strictly greater so a
  // partial first millisecond never cuts the wait short (all ones never fires)
  wire hit_accept = ce && !take && accept_to_en && (accept_to_ms != '0)
                    && (cur_len_q != '0) && (idle_ms_q > accept_to_ms);
  wire capture = hit_delim | hit_accept;
  // Same reasoning: live slots live at least the full programmed time
  wire live_expire = ce && live_valid && (active_to_ms != '0) && (live_ms_q > active_to_ms);

  // Delimiter register with defaults at reset and on reload
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      delim_q <= DELIM_RST;
      dlen_q  <= DELIM_LEN_DEFAULT;
    end
    else if (ce && defaults_reload)
    begin
      delim_q <= DELIM_RST;
      dlen_q  <= DELIM_LEN_DEFAULT;
    end
    else if (ce && delim_wr && delim_wr_len <= DLEN_W'(DELIM_MAX))
    begin
      delim_q <= delim_wr_data;
      dlen_q  <= delim_wr_len;
    end
  end

  assign delim_bytes = delim_q;
  assign delim_len   = dlen_q;

  // Prescaler and the two millisecond counters
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pre_q     <= '0;
      idle_ms_q <= '0;
      live_ms_q <= '0;
    end
    else if (ce)
    begin
      pre_q     <= ms_tick ? '0 : pre_q + PW'(1);
      idle_ms_q <= (take || capture || cur_len_q == '0) ? '0
                 : (ms_tick && idle_ms_q != '1) ? idle_ms_q + MS_W'(1) : idle_ms_q;
      live_ms_q <= capture ? '0
                 : (ms_tick && live_valid && live_ms_q != '1) ? live_ms_q + MS_W'(1) : live_ms_q;
    end
  end

  // Working buffer restarts after each capture or while disabled
  always_ff @(posedge ref_clk)
  begin
    if (rst || (ce && (capture || !recognizer_en)))
    begin
      cur_text_q <= '0;
      cur_len_q  <= '0;
      cur_hash_q <= FNV_OFFSET;
      win_q      <= '0;
    end
    else if (ce)
    begin
      cur_text_q <= text_app;
      cur_len_q  <= len_app;
      cur_hash_q <= hash_app;
      win_q      <= win_app;
    end
  end

  // Persistent slots: a capture wins over a clear in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst || (ce && clear_slots && !capture))
    begin
      last_message_text      <= '0;
      last_message_hexdigits <= '0;
      last_message_digest    <= '0;
      last_message_len       <= '0;
    end
    else if (ce && capture)
    begin
      last_message_text      <= text_app;
      last_message_hexdigits <= hex_app;
      last_message_digest    <= hash_app;
      last_message_len       <= len_app;
    end
  end

  // Live slots: written on capture, erased by timeout or clear
  always_ff @(posedge ref_clk)
  begin
    if (rst || (ce && !capture && (clear_slots || live_expire)))
    begin
      live_message_text      <= '0;
      live_message_hexdigits <= '0;
      live_message_digest    <= '0;
      live_valid             <= 1'b0;
    end
    else if (ce && capture)
    begin
      live_message_text      <= text_app;
      live_message_hexdigits <= hex_app;
      live_message_digest    <= hash_app;
      live_valid             <= 1'b1;
    end
  end

  assign live_hexdigits_alias = live_message_hexdigits;

  // Capture strobe, also stalls the buffer for one cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cap_q <= 1'b0;
    end
    else if (ce)
    begin
      cap_q <= capture;
    end
  end

  assign capture_done = cap_q;

endmodule // smr_recognizer

// >>> verification/smr_checker.sv
// Port-level assertions for the serial message recognizer
module smr_checker #(
  parameter int unsigned MSG_MAX   = 16,
  parameter int unsigned DELIM_MAX = 4,
  parameter int unsigned MS_CYCLES = 8
) (
  input wire logic                            ref_clk,
  input wire logic                            rst,
  input wire logic                            ce,
  input wire logic                            recognizer_en,
  input wire logic                            defaults_reload,
  input wire logic                            clear_slots,
  input wire logic                            rx_ready,
  input wire logic [smr_pkg::MS_W-1:0]        active_to_ms,
  input wire logic [DELIM_MAX*8-1:0]          delim_bytes,
  input wire logic [smr_pkg::DLEN_W-1:0]      delim_len,
  input wire logic [MSG_MAX*8-1:0]            last_message_text,
  input wire logic [31:0]                     last_message_digest,
  input wire logic [$clog2(MSG_MAX+1)-1:0]    last_message_len,
  input wire logic [MSG_MAX*8-1:0]            live_message_text,
  input wire logic [MSG_MAX*16-1:0]           live_message_hexdigits,
  input wire logic [MSG_MAX*16-1:0]           live_hexdigits_alias,
  input wire logic [31:0]                     live_message_digest,
  input wire logic                            live_valid,
  input wire logic                            capture_done
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned   DW      = DELIM_MAX * 8;
  localparam logic [DW-1:0] DLM_RST = DW'(smr_pkg::DELIM_DEFAULT);
  logic [31:0] live_cnt_q;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Age of the live slots; restarts on each capture
  always_ff @(posedge ref_clk) live_cnt_q <= (rst || capture_done || !live_valid) ? '0 : live_cnt_q + 1;
  a_reset_delim: assert property (disable iff (1'b0) rst |=> delim_len == smr_pkg::DELIM_LEN_DEFAULT
    && delim_bytes == DLM_RST)
    else $error("delimiter not default after reset");
  a_reload_delim: assert property (ce && defaults_reload |=> delim_len == smr_pkg::DELIM_LEN_DEFAULT
    && delim_bytes == DLM_RST)
    else $error("reload did not restore delimiter");
  a_done_pulse: assert property (capture_done |=> !capture_done)
    else $error("capture pulse longer than one cycle");
  a_alias_copy: assert property (live_hexdigits_alias == live_message_hexdigits)
    else $error("hex alias differs from live hex");
  a_done_both: assert property (capture_done |-> live_valid && live_message_digest == last_message_digest
    && live_message_text == last_message_text)
    else $error("live and persistent slots differ at capture");
  a_clear_empty: assert property (ce && clear_slots |=> capture_done
    || (last_message_len == 0 && !live_valid && last_message_digest == 32'h0))
    else $error("slots not erased by clear");
  a_expire_keep: assert property ($fell(live_valid) && !$past(clear_slots) && !$past(rst)
    |-> $stable(last_message_digest)
    && live_message_digest == 32'h0 && live_message_text == '0)
    else $error("expiry touched persistent or left live data");
  a_off_quiet: assert property (!recognizer_en [*3] |-> !capture_done)
    else $error("capture while recognizer disabled");
  a_live_bound: assert property (live_valid && active_to_ms != 0
    |-> live_cnt_q <= (active_to_ms + 1) * MS_CYCLES + 2)
    else $error("live slots outlived active timeout");
  a_live_early: assert property ($fell(live_valid) && !$past(clear_slots) && !$past(rst)
    |-> live_cnt_q >= active_to_ms * MS_CYCLES)
    else $error("live slots erased before active timeout");
  c_capture: cover property (capture_done);
  c_expire: cover property ($fell(live_valid));
  c_full: cover property (!rx_ready);
endmodule // smr_checker

bind smr_recognizer smr_checker #(.MSG_MAX(MSG_MAX), .DELIM_MAX(DELIM_MAX), .MS_CYCLES(MS_CYCLES)) u_chk (.*);

// >>> verification/smr_codec_model.sv
// Behavioural model of the serial equipment that feeds received bytes
module smr_codec_model (
  input wire logic  ref_clk,
  input wire logic  stall,
  input wire logic  rx_ready,
  output logic [7:0] rx_data,
  output logic       rx_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  byte unsigned q[$];
  logic         took;
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    took = 1'b0;
  end
  // Handshake as seen at the rising edge
  always @(posedge ref_clk) took <= rx_valid && rx_ready;
  // Byte held until taken; an idle line shows changing junk
  always @(negedge ref_clk)
  begin
    if (!rx_valid || took)
    begin
      rx_valid <= q.size() != 0 && !stall;
      rx_data <= (q.size() != 0 && !stall) ? q.pop_front() : ~rx_data;
    end
  end
endmodule // smr_codec_model

// >>> verification/smr_recognizer_tb.sv
// Self-checking bench for the serial message recognizer
module smr_recognizer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smr_pkg::*;
  logic         ref_clk, rst, ce, recognizer_en, rx_valid, rx_ready, delim_wr, defaults_reload;
  logic         clear_slots, accept_to_en, live_valid, capture_done, stall, slow, saw_full;
  logic [7:0]   rx_data;
  logic [2:0]   delim_wr_len, delim_len;
  logic [15:0]  accept_to_ms, active_to_ms;
  logic [31:0]  delim_wr_data, delim_bytes, last_message_digest, live_message_digest;
  logic [4:0]   last_message_len;
  logic [127:0] last_message_text, live_message_text;
  logic [255:0] last_message_hexdigits, live_message_hexdigits, live_hexdigits_alias;
  logic [16:0]  lfsr;
  int           bad_count, n_tests, n_caps, cyc, n0;
  byte unsigned msg[$];
  smr_recognizer #(.MS_CYCLES(8)) dut (.*);
  smr_codec_model peer (.*);
  // Free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Capture counter, stall pattern and hang guard
  always @(negedge ref_clk)
  begin
    cyc++;
    if (capture_done) n_caps++;
    if (!rx_ready) saw_full = 1'b1;
    stall <= slow & cyc[1];
    if (cyc > 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  function automatic logic [7:0] hx(logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic chk(logic [255:0] got, logic [255:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic put(string s);
    msg.delete();
    foreach (s[i]) msg.push_back(s[i]);
  endtask
  // Hand the message to the far side and wait for the captures
  task automatic send(int caps);
    n0 = n_caps;
    foreach (msg[i]) peer.q.push_back(msg[i]);
    repeat (400) if (n_caps < n0 + caps) @(negedge ref_clk);
  endtask
  // Expected text, hex digits and digest from the message bytes
  task automatic check_msg(string name);
    logic [127:0] t;
    logic [255:0] h;
    logic [31:0]  d;
    t = '0;
    h = '0;
    d = FNV_OFFSET;
    foreach (msg[i])
    begin
      d = (d ^ msg[i]) * FNV_PRIME;
      if (i < 16) t[8*i+:8] = msg[i];
      if (i < 16) h[16*i+:16] = {hx(msg[i][3:0]), hx(msg[i][7:4])};
    end
    chk(last_message_text, t);
    chk(last_message_hexdigits, h);
    chk(last_message_digest, d);
    chk(live_message_text, t);
    chk(live_message_digest, d);
    chk(live_message_hexdigits, h);
    chk(live_hexdigits_alias, h);
    chk(last_message_len, (msg.size() > 16) ? 16 : msg.size());
    $display("test %s done", name);
  endtask
  initial
  begin
    {rst, ce, recognizer_en, slow, stall, saw_full} = 6'b111000;
    {delim_wr, defaults_reload, clear_slots, accept_to_en} = 4'h0;
    {delim_wr_data, delim_wr_len, accept_to_ms, active_to_ms} = {32'h3a, 3'h1, 16'h1, 16'h2};
    {bad_count, n_tests, n_caps, cyc} = '0;
    lfsr = 17'h13eed; // Seed 81645
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    chk(delim_bytes, 32'h0000_0d0a);
    chk({delim_len, last_message_len, live_valid}, {3'h2, 5'h0, 1'b0});
    delim_wr = 1'b1;
    @(negedge ref_clk) delim_wr = 1'b0;
    put("Login:");
    send(1);
    check_msg("colon");
    repeat (14) @(negedge ref_clk);
    chk(live_valid, 1'b1);
    repeat (16) @(negedge ref_clk);
    chk({live_valid, live_message_digest}, 33'h0);
    chk(last_message_len, 5'h6);
    $display("test expiry done");
    repeat (8)
    begin
      msg.delete();
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      slow = lfsr[9];
      repeat (1 + lfsr % 20)
      begin
        lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
        msg.push_back((lfsr[7:0] == 8'h3a) ? 8'h41 : lfsr[7:0]);
      end
      msg.push_back(8'h3a);
      send(1);
      check_msg("random");
    end
    slow = 1'b0;
    put("::::::");
    send(6);
    chk({n_caps - n0, saw_full}, {32'h6, 1'b1});
    put(":");
    check_msg("burst");
    recognizer_en = 1'b0;
    put("ab:");
    send(1);
    chk(n_caps, n0);
    $display("test disable done");
    recognizer_en = 1'b1;
    put("xy:");
    send(1);
    check_msg("enable");
    clear_slots = 1'b1;
    @(negedge ref_clk) clear_slots = 1'b0;
    chk({last_message_len, last_message_digest, live_valid}, 38'h0);
    $display("test clear done");
    accept_to_en = 1'b1;
    put("ab");
    send(1);
    check_msg("idle");
    accept_to_en = 1'b0;
    defaults_reload = 1'b1;
    @(negedge ref_clk) defaults_reload = 1'b0;
    put("hi\015\012");
    send(1);
    check_msg("reload");
    summarize();
  end
endmodule // smr_recognizer_tb
